// file: core/rtc_top.sv
// Reset time-out sequencer and reset cause tracker
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Power-up delay starts after power-on pulse ends; start-up count follows it.
// - Resistor-capacitor mode with power-up timer disabled gives no time-out on power-on.
// - Time-outs ignore the reset pin; execution starts when pin releases.
// - Crystal: delay plus 1024 periods on power-up/brown-out, 1024 on wake.
// - Brown-out clears cause bit 0; software sets it.
// - Power-on clears cause bit 1, others leave it; software sets it.
// - Parity error clears cause bit 2; power-on sets it.
// - Cause bit 7 mirrors parity-check enable and no reset changes it.
// - Each reset kind sets the cause and sleep/expiry flags as tabled.
// - Resets load program counter zero; wakes continue at next address.
// - Interrupt wake with global enable vectors to 0004h after one instruction.
// - Status register takes the tabled value for each reset kind.
// - Option and direction go all ones, interrupt control cleared (bit 0 kept on resets other than power-on); wakes keep them.
// - Interrupt wake keeps registers but sets the waking interrupt flags.
// - Start-up count only in crystal modes, after power-on, brown-out or wake.
// - Power-up timer runs when its configuration bit is clear.
// - Brown-out during the power-up delay restarts the delay.
module rtc_top
  import rtc_pkg::*;
#(
  parameter logic [POWER_UP_TIMER_W-1:0] POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_W'(POWER_UP_TIMER_CYC),
  parameter logic [OST_W-1:0] OST_LEN = OST_W'(OST_PERIODS)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_pulse,
  input wire logic brown_out_det,
  input wire logic external_reset_pin_b,
  input wire logic watchdog_timeout,
  input wire logic osc_clk_in,
  input wire logic [1:0] osc_mode_cfg,
  input wire logic power_timer_disable_cfg,
  input wire logic parity_check_enable_cfg,
  input wire logic brownout_detect_enable_cfg,
  input wire logic parity_error,
  input wire logic sleep_enter,
  input wire logic irq_wake,
  input wire logic [7:0] irq_wake_flags,
  input wire logic [12:0] pc_current,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic core_reset,
  output logic core_hold,
  output logic pc_load,
  output logic [12:0] pc_value,
  output logic irq_vector_after,
  output logic irq_out
);
  logic por_s;
  logic bor_s;
  logic pin_s;
  logic wdt_s;
  logic osc_s;
  logic [4:0] cfg_s;
  logic wdt_d_reg;
  logic osc_d_reg;
  logic sleeping_reg;
  rtc_state_t state_reg;
  rtc_cause_t cause_reg;
  logic need_power_up_timer_reg;
  logic need_ost_reg;
  logic [7:0] status_reg;
  logic [2:0] cause_bits_reg;
  logic [7:0] option_reg;
  logic [7:0] dir_reg;
  logic [7:0] intctl_reg;
  logic [EV_W-1:0] evt_stat_reg;
  logic [EV_W-1:0] evt_en_reg;
  logic power_up_timer_done;
  logic ost_done;
  logic ev_valid;
  rtc_cause_t ev_cause;
  logic crystal;
  logic wdt_edge;
  logic osc_tick;
  logic is_wake;
  logic in_timer;
  logic sw_wr_status;
  logic sw_wr_cause;

  // Pins and the oscillator come from outside the clock domain
  rtc_sync #(.WIDTH(1), .INIT(1'b1)) u_sync_por (
    .clk(clk), .rst_b(rst_b), .d(por_pulse), .q(por_s));
  rtc_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_bor (
    .clk(clk), .rst_b(rst_b), .d(brown_out_det), .q(bor_s));
  rtc_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_pin (
    .clk(clk), .rst_b(rst_b), .d(external_reset_pin_b), .q(pin_s));
  rtc_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_wdt (
    .clk(clk), .rst_b(rst_b), .d(watchdog_timeout), .q(wdt_s));
  rtc_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_osc (
    .clk(clk), .rst_b(rst_b), .d(osc_clk_in), .q(osc_s));
  rtc_sync #(.WIDTH(5), .INIT(5'h00)) u_sync_cfg (
    .clk(clk), .rst_b(rst_b),
    .d({osc_mode_cfg, power_timer_disable_cfg, parity_check_enable_cfg, brownout_detect_enable_cfg}),
    .q(cfg_s));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdt_d_reg <= 1'b0;
      osc_d_reg <= 1'b0;
    end
    else
    begin
      wdt_d_reg <= wdt_s;
      osc_d_reg <= osc_s;
    end
  end

  assign wdt_edge = wdt_s && !wdt_d_reg;
  // One oscillator period per rising edge; the oscillator must be below half of clk
  assign osc_tick = osc_s && !osc_d_reg;
  assign crystal = (rtc_osc_t'(cfg_s[4:3]) != OSC_RC);
  assign is_wake = (cause_reg == CZ_WDT_WAKE) || (cause_reg == CZ_IRQ_WAKE);
  assign in_timer = (state_reg == ST_POWER_UP_TIMER) || (state_reg == ST_OST);

  // Supply events win at any time; the rest only while running or asleep
  always_comb
  begin
    ev_valid = 1'b1;
    ev_cause = CZ_POR;
    if (por_s)
      ev_cause = CZ_POR;
    else if (bor_s && cfg_s[0])
      ev_cause = CZ_BOR;
    else if (state_reg != ST_RUN)
      ev_valid = 1'b0;
    else if (!pin_s)
      ev_cause = sleeping_reg ? CZ_EXT_SLEEP : CZ_EXT_RUN;
    else if (parity_error && cfg_s[1] && !sleeping_reg)
      ev_cause = CZ_PARITY;
    else if (wdt_edge)
      ev_cause = sleeping_reg ? CZ_WDT_WAKE : CZ_WDT_RST;
    else if (irq_wake && sleeping_reg)
      ev_cause = CZ_IRQ_WAKE;
    else
      ev_valid = 1'b0;
  end

  rtc_delay #(.WIDTH(POWER_UP_TIMER_W), .LEN(POWER_UP_TIMER_CYCLES)) u_power_up_timer (
    .clk(clk), .rst_b(rst_b), .restart(ev_valid || (state_reg != ST_POWER_UP_TIMER)),
    .tick(1'b1), .done(power_up_timer_done));
  rtc_delay #(.WIDTH(OST_W), .LEN(OST_LEN)) u_ost (
    .clk(clk), .rst_b(rst_b), .restart(ev_valid || (state_reg != ST_OST)),
    .tick(osc_tick), .done(ost_done));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_POWER_UP_TIMER;
      cause_reg <= CZ_POR;
      need_power_up_timer_reg <= 1'b0;
      need_ost_reg <= 1'b0;
    end
    else if (ev_valid)
    begin
      state_reg <= ST_POWER_UP_TIMER;
      cause_reg <= ev_cause;
      need_power_up_timer_reg <= ((ev_cause == CZ_POR) && !cfg_s[2]) || (ev_cause == CZ_BOR);
      need_ost_reg <= crystal && ((ev_cause == CZ_POR) || (ev_cause == CZ_BOR)
        || (ev_cause == CZ_WDT_WAKE) || (ev_cause == CZ_IRQ_WAKE));
    end
    else
    begin
      unique case (state_reg)
        ST_POWER_UP_TIMER:
          if (!need_power_up_timer_reg || power_up_timer_done)
            state_reg <= ST_OST;
        ST_OST:
          if (!need_ost_reg || ost_done)
            state_reg <= ST_PIN;
        ST_PIN:
          if (pin_s)
            state_reg <= ST_RUN;
        ST_RUN:
          state_reg <= ST_RUN;
      endcase
    end
  end

  // Core is held for every state short of running; reset is asserted too except after wakes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      core_reset <= 1'b1;
      core_hold <= 1'b1;
    end
    else
    begin
      core_reset <= ev_valid ? !((ev_cause == CZ_WDT_WAKE) || (ev_cause == CZ_IRQ_WAKE))
        : (core_reset && !(state_reg == ST_PIN && pin_s));
      core_hold <= ev_valid || (core_hold && !(state_reg == ST_PIN && pin_s));
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_load <= 1'b0;
      pc_value <= PC_RESET_VEC;
      irq_vector_after <= 1'b0;
    end
    else
    begin
      pc_load <= !ev_valid && (state_reg == ST_PIN) && pin_s;
      if (!ev_valid && (state_reg == ST_PIN) && pin_s)
      begin
        pc_value <= is_wake ? (pc_current + 13'h0001) : PC_RESET_VEC;
        irq_vector_after <= (cause_reg == CZ_IRQ_WAKE) && intctl_reg[INT_GIE];
      end
    end
  end

  // Sleep entry clears the sleep flag and sets the expiry flag
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sleeping_reg <= 1'b0;
    else if (ev_valid)
      sleeping_reg <= 1'b0;
    else if (sleep_enter && (state_reg == ST_RUN))
      sleeping_reg <= 1'b1;
  end

  assign sw_wr_status = wr_en && (addr == ADDR_STATUS);
  assign sw_wr_cause = wr_en && (addr == ADDR_CAUSE);

  // Flags 4:3 are hardware-owned; a reset event beats a same-cycle write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      status_reg <= STATUS_RST;
    else if (ev_valid)
    begin
      unique case (ev_cause)
        CZ_POR: status_reg <= STATUS_RST;
        CZ_EXT_RUN: status_reg <= {3'h0, status_reg[4:0]};
        CZ_EXT_SLEEP: status_reg <= {5'h02, status_reg[2:0]};
        CZ_WDT_RST: status_reg <= {5'h01, status_reg[2:0]};
        CZ_WDT_WAKE: status_reg <= {status_reg[7:5], 2'b00, status_reg[2:0]};
        CZ_BOR, CZ_PARITY: status_reg <= {5'h03, status_reg[2:0]};
        CZ_IRQ_WAKE: status_reg <= {status_reg[7:5], 2'b10, status_reg[2:0]};
      endcase
    end
    else if (sleep_enter && (state_reg == ST_RUN))
    begin
      status_reg[ST_EXPIRY_N] <= 1'b1;
      status_reg[ST_SLEEP_N] <= 1'b0;
    end
    else if (sw_wr_status)
      status_reg <= {wdata[7:5], status_reg[4:3], wdata[2:0]};
  end

  // Hardware clears beat a same-cycle software write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cause_bits_reg <= CAUSE_RST;
    else
    begin
      if (sw_wr_cause)
        cause_bits_reg <= wdata[2:0];
      if (ev_valid && (ev_cause == CZ_POR))
      begin
        cause_bits_reg[RC_POR_N] <= 1'b0;
        cause_bits_reg[RC_PER_N] <= 1'b1;
        if (sw_wr_cause)
          cause_bits_reg[RC_BOR_N] <= wdata[RC_BOR_N];
        else
          cause_bits_reg[RC_BOR_N] <= cause_bits_reg[RC_BOR_N];
      end
      else if (ev_valid && (ev_cause == CZ_BOR))
        cause_bits_reg[RC_BOR_N] <= 1'b0;
      else if (ev_valid && (ev_cause == CZ_PARITY))
        cause_bits_reg[RC_PER_N] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      option_reg <= OPTION_RST;
      dir_reg <= DIR_RST;
    end
    else if (ev_valid && !((ev_cause == CZ_WDT_WAKE) || (ev_cause == CZ_IRQ_WAKE)))
    begin
      option_reg <= OPTION_RST;
      dir_reg <= DIR_RST;
    end
    else
    begin
      if (wr_en && (addr == ADDR_OPTION))
        option_reg <= wdata;
      if (wr_en && (addr == ADDR_DIR))
        dir_reg <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      intctl_reg <= INTCTL_RST;
    else if (ev_valid && (ev_cause == CZ_POR))
      intctl_reg <= INTCTL_RST;
    else if (ev_valid && !((ev_cause == CZ_WDT_WAKE) || (ev_cause == CZ_IRQ_WAKE)))
      intctl_reg <= {INTCTL_RST[7:1], intctl_reg[0]};
    else if (ev_valid && (ev_cause == CZ_IRQ_WAKE))
      intctl_reg <= intctl_reg | irq_wake_flags;
    else if (wr_en && (addr == ADDR_INTCTL))
      intctl_reg <= wdata;
  end

  // Sticky event bits: a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      evt_stat_reg <= '0;
    else
    begin
      if (wr_en && (addr == ADDR_EVT_CLR))
        evt_stat_reg <= evt_stat_reg & ~wdata[EV_W-1:0];
      // Interrupt wake has no status bit; its code would index past the top
      if (ev_valid && (ev_cause != CZ_POR) && (ev_cause != CZ_IRQ_WAKE))
        evt_stat_reg[ev_cause[2:0]] <= 1'b1;
      else if (ev_valid && (ev_cause == CZ_POR))
        evt_stat_reg[0] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      evt_en_reg <= '0;
    else if (wr_en && (addr == ADDR_EVT_EN))
      evt_en_reg <= wdata[EV_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_out <= 1'b0;
    else
      irq_out <= |(evt_stat_reg & evt_en_reg);
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (!rd_en)
      rdata <= 8'h00;
    else
    begin
      unique case (addr)
        ADDR_STATUS: rdata <= status_reg;
        ADDR_CAUSE: rdata <= {cfg_s[1], 4'h0, cause_bits_reg};
        ADDR_OPTION: rdata <= option_reg;
        ADDR_DIR: rdata <= dir_reg;
        ADDR_INTCTL: rdata <= intctl_reg;
        ADDR_EVT_STAT: rdata <= {1'b0, evt_stat_reg};
        ADDR_EVT_EN: rdata <= {1'b0, evt_en_reg};
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule : rtc_top
`default_nettype wire

// file: core/rtc_pkg.sv
// Constants for the reset time-out and cause tracker
package rtc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Power-up delay in microseconds, rounded down to whole cycles
  localparam int unsigned POWER_UP_TIMER_US = 72_000;
  localparam int unsigned POWER_UP_TIMER_CYC = POWER_UP_TIMER_US * (CLK_HZ / 1_000_000);
  localparam int POWER_UP_TIMER_W = 23;
  localparam int unsigned OST_PERIODS = 1024;
  localparam int OST_W = 11;

  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_INTCTL = 8'h0B;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_DIR = 8'h86;
  localparam logic [7:0] ADDR_CAUSE = 8'h8E;
  localparam logic [7:0] ADDR_EVT_STAT = 8'h90;
  localparam logic [7:0] ADDR_EVT_CLR = 8'h91;
  localparam logic [7:0] ADDR_EVT_EN = 8'h92;

  // Status bit positions
  localparam int ST_EXPIRY_N = 4;
  localparam int ST_SLEEP_N = 3;
  // Reset cause and interrupt control bit positions
  localparam int RC_BOR_N = 0;
  localparam int RC_POR_N = 1;
  localparam int RC_PER_N = 2;
  localparam int RC_PAR_EN = 7;
  localparam int INT_GIE = 7;

  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [2:0] CAUSE_RST = 3'h6;
  localparam logic [12:0] PC_RESET_VEC = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC = 13'h0004;

  localparam int EV_W = 7;

  typedef enum logic [1:0] {
    OSC_LP = 2'h0,
    OSC_XT = 2'h1,
    OSC_HS = 2'h2,
    OSC_RC = 2'h3
  } rtc_osc_t;

  typedef enum logic [2:0] {
    CZ_POR = 3'h0,
    CZ_BOR = 3'h1,
    CZ_EXT_RUN = 3'h2,
    CZ_EXT_SLEEP = 3'h3,
    CZ_WDT_RST = 3'h4,
    CZ_WDT_WAKE = 3'h5,
    CZ_PARITY = 3'h6,
    CZ_IRQ_WAKE = 3'h7
  } rtc_cause_t;

  typedef enum logic [1:0] {
    ST_POWER_UP_TIMER = 2'b00,
    ST_OST = 2'b01,
    ST_PIN = 2'b11,
    ST_RUN = 2'b10
  } rtc_state_t;
endpackage : rtc_pkg

// file: core/rtc_sync.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module rtc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : rtc_sync
`default_nettype wire

// file: core/rtc_delay.sv
// Up-counter that reports when a fixed number of ticks has passed
`timescale 1ns/1ps
`default_nettype none
module rtc_delay #(
  parameter int WIDTH = 11,
  parameter logic [WIDTH-1:0] LEN = '1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic tick,
  output logic done
);
  logic [WIDTH-1:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_reg <= '0;
    else if (restart)
      cnt_reg <= '0;
    else if (tick && (cnt_reg != LEN))
      cnt_reg <= cnt_reg + 1'b1;
  end

  assign done = (cnt_reg == LEN);
endmodule : rtc_delay
`default_nettype wire

// file: verification/rtc_monitor.sv
// Port assertions for the reset time-out sequencer
`timescale 1ns/1ps
`default_nettype none
module rtc_monitor
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic external_reset_pin_b,
  input wire logic parity_check_enable_cfg,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic core_reset,
  input wire logic core_hold,
  input wire logic pc_load,
  input wire logic [12:0] pc_value,
  input wire logic irq_vector_after
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Pin low long enough to pass the synchroniser
  sequence pin_low_s;
    !external_reset_pin_b [*4];
  endsequence
  sequence release_s;
    core_hold ##1 !core_hold;
  endsequence

  cause_mirror_a: assert property ($past(rd_en) && $past(addr) == ADDR_CAUSE
    |-> rdata[RC_PAR_EN] == parity_check_enable_cfg) else $error("cause bit 7 differs from config");
  release_pulse_a: assert property (release_s |-> pc_load ##1 !pc_load)
    else $error("release without single load pulse");
  load_at_release_a: assert property (pc_load |-> $fell(core_hold))
    else $error("load pulse outside release");
  reset_vector_a: assert property ($fell(core_reset) |-> pc_load && pc_value == PC_RESET_VEC)
    else $error("reset release without zero vector");
  reset_holds_a: assert property (core_reset |-> core_hold)
    else $error("core in reset but not held");
  pin_hold_a: assert property (pin_low_s |-> core_hold)
    else $error("core runs with reset pin low");
  pin_release_a: assert property ($fell(core_hold) |-> $past(external_reset_pin_b, 2))
    else $error("release while reset pin low");
  vector_flag_a: assert property ($rose(irq_vector_after) |-> pc_load)
    else $error("vector flag rose outside release");
endmodule : rtc_monitor

bind rtc_top rtc_monitor i_mon (.clk(clk), .rst_b(rst_b), .external_reset_pin_b(external_reset_pin_b),
  .parity_check_enable_cfg(parity_check_enable_cfg), .addr(addr), .rd_en(rd_en), .rdata(rdata),
  .core_reset(core_reset), .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value),
  .irq_vector_after(irq_vector_after));
`default_nettype wire

// file: verification/rtc_top_test.sv
// Self-checking bench for the reset time-out and cause tracker
`timescale 1ns/1ps
`default_nettype none
module rtc_top_test;
  import rtc_pkg::*;
  // Short counts keep the run brief; expectations derive from these
  localparam int POWER_UP_TIMER_SIM = 20;
  localparam int OST_SIM = 8;
  localparam int OSC_CYC = 6;
  localparam int T_LO = POWER_UP_TIMER_SIM + (OST_SIM - 1) * OSC_CYC;
  localparam int T_HI = POWER_UP_TIMER_SIM + OST_SIM * OSC_CYC + 20;
  localparam int W_LO = (OST_SIM - 2) * OSC_CYC;
  localparam int W_HI = OST_SIM * OSC_CYC + 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_pulse = 1'b1;
  logic brown_out_det = 1'b0;
  logic external_reset_pin_b = 1'b1;
  logic watchdog_timeout = 1'b0;
  logic osc_clk_in = 1'b0;
  logic [1:0] osc_mode_cfg = OSC_XT;
  logic power_timer_disable_cfg = 1'b0;
  logic parity_check_enable_cfg = 1'b1;
  logic brownout_detect_enable_cfg = 1'b1;
  logic parity_error = 1'b0, sleep_enter = 1'b0, irq_wake = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] irq_wake_flags = 8'h00, addr = 8'h00, wdata = 8'h00;
  logic [12:0] pc_current = 13'h0000;
  logic [7:0] rdata;
  logic [12:0] pc_value;
  logic core_reset, core_hold, pc_load, irq_vector_after, irq_out;
  int n_errors = 0, samples_checked = 0, cycles = 0, n;

  rtc_top #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_W'(POWER_UP_TIMER_SIM)), .OST_LEN(OST_W'(OST_SIM))) i_dut (.clk(clk), .rst_b(rst_b),
    .por_pulse(por_pulse), .brown_out_det(brown_out_det), .external_reset_pin_b(external_reset_pin_b),
    .watchdog_timeout(watchdog_timeout), .osc_clk_in(osc_clk_in), .osc_mode_cfg(osc_mode_cfg),
    .power_timer_disable_cfg(power_timer_disable_cfg), .parity_check_enable_cfg(parity_check_enable_cfg),
    .brownout_detect_enable_cfg(brownout_detect_enable_cfg), .parity_error(parity_error),
    .sleep_enter(sleep_enter), .irq_wake(irq_wake), .irq_wake_flags(irq_wake_flags),
    .pc_current(pc_current), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .core_reset(core_reset), .core_hold(core_hold), .pc_load(pc_load), .pc_value(pc_value),
    .irq_vector_after(irq_vector_after), .irq_out(irq_out));

  always #5 clk = ~clk;
  // Oscillator well below the synchroniser limit
  always #30 osc_clk_in = ~osc_clk_in;

  task automatic finish_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check("rdata", 16'(rdata & m), 16'(e));
  endtask : rd

  // Counts cycles to the release pulse, bounded
  task automatic rel(input int lo, input int hi);
    n = 0;
    #1;
    while (pc_load !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("release cycles", 16'(n >= lo && n <= hi), 16'h0001);
  endtask : rel

  task automatic por(input logic [1:0] mode, input logic dis, input logic pin, input int lo, input int hi);
    @(posedge clk);
    osc_mode_cfg <= mode;
    power_timer_disable_cfg <= dis;
    external_reset_pin_b <= pin;
    por_pulse <= 1'b1;
    repeat (4) @(posedge clk);
    por_pulse <= 1'b0;
    if (!pin)
    begin
      repeat (150) @(posedge clk);
      #1;
      check("core_hold", 16'(core_hold), 16'h0001);
      @(posedge clk);
      external_reset_pin_b <= 1'b1;
    end
    rel(lo, hi);
    check("pc_value", 16'(pc_value), 16'(PC_RESET_VEC));
  endtask : por

  task automatic sleep_now;
    @(posedge clk);
    sleep_enter <= 1'b1;
    pc_current <= 13'h0123;
    @(posedge clk);
    sleep_enter <= 1'b0;
  endtask : sleep_now

  task automatic wdt_edge;
    watchdog_timeout <= 1'b1;
    repeat (3) @(posedge clk);
    watchdog_timeout <= 1'b0;
  endtask : wdt_edge

  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    por(OSC_XT, 1'b0, 1'b1, T_LO, T_HI);
    rd(ADDR_STATUS, 8'h18);
    rd(ADDR_CAUSE, 8'h84);
    rd(ADDR_OPTION, 8'hFF);
    rd(ADDR_DIR, 8'hFF);
    rd(ADDR_INTCTL, 8'h00);
    por(OSC_XT, 1'b0, 1'b0, 0, 6);
    wr(ADDR_STATUS, 8'hE7);
    wr(ADDR_CAUSE, 8'h07);
    wr(ADDR_OPTION, 8'h00);
    wr(ADDR_INTCTL, 8'h81);
    @(posedge clk);
    external_reset_pin_b <= 1'b0;
    repeat (4) @(posedge clk);
    external_reset_pin_b <= 1'b1;
    rel(0, 12);
    rd(ADDR_STATUS, 8'h1F);
    rd(ADDR_CAUSE, 8'h87);
    rd(ADDR_OPTION, 8'hFF);
    rd(ADDR_INTCTL, 8'h01);
    @(posedge clk);
    wdt_edge();
    rel(0, 12);
    rd(ADDR_STATUS, 8'h0F);
    wr(ADDR_STATUS, 8'hA5);
    wr(ADDR_OPTION, 8'h55);
    sleep_now();
    wdt_edge();
    #1;
    check("hold and reset", 16'({core_hold, core_reset}), 16'h0002);
    rel(W_LO, W_HI);
    check("pc_value", 16'(pc_value), 16'h0124);
    check("irq_vector_after", 16'(irq_vector_after), 16'h0000);
    rd(ADDR_STATUS, 8'hA5);
    rd(ADDR_OPTION, 8'h55);
    wr(ADDR_INTCTL, 8'h80);
    sleep_now();
    irq_wake <= 1'b1;
    irq_wake_flags <= 8'h02;
    rel(W_LO, W_HI);
    irq_wake <= 1'b0;
    check("pc_value", 16'(pc_value), 16'h0124);
    check("irq_vector_after", 16'(irq_vector_after), 16'h0001);
    rd(ADDR_STATUS, 8'hB5);
    rd(ADDR_INTCTL, 8'h82);
    rd(ADDR_EVT_STAT, 8'h35);
    wr(ADDR_EVT_EN, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    check("irq_out", 16'(irq_out), 16'h0001);
    wr(ADDR_EVT_STAT, 8'h00);
    wr(ADDR_EVT_CLR, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    check("irq_out", 16'(irq_out), 16'h0000);
    rd(ADDR_EVT_STAT, 8'h25);
    rd(ADDR_EVT_CLR, 8'h00);
    wr(8'h55, 8'hAA);
    rd(8'h55, 8'h00);
    wr(ADDR_CAUSE, 8'h07);
    @(posedge clk);
    brown_out_det <= 1'b1;
    repeat (4) @(posedge clk);
    brown_out_det <= 1'b0;
    // Second dip lands inside the power-up delay
    repeat (10) @(posedge clk);
    brown_out_det <= 1'b1;
    repeat (4) @(posedge clk);
    brown_out_det <= 1'b0;
    rel(T_LO, T_HI);
    rd(ADDR_STATUS, 8'h1D);
    rd(ADDR_CAUSE, 8'h86);
    @(posedge clk);
    parity_error <= 1'b1;
    @(posedge clk);
    parity_error <= 1'b0;
    rel(0, 12);
    rd(ADDR_CAUSE, 8'h82);
    rd(ADDR_STATUS, 8'h1D);
    wr(ADDR_CAUSE, 8'h07);
    por(OSC_RC, 1'b1, 1'b1, 0, 12);
    rd(ADDR_CAUSE, 8'h84, 8'hFE);
    finish_test();
  end
endmodule : rtc_top_test
`default_nettype wire
